// File: logic/csc_ctrl_pkg.sv
// constants shared by the colour-space control block
package csc_ctrl_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [9:0] OFF_CONTROL = 10'h000;
	localparam logic [9:0] OFF_STATUS = 10'h004;
	localparam logic [9:0] OFF_VERSION = 10'h010;
	localparam logic [9:0] OFF_ACTIVE_SIZE = 10'h020;
	localparam logic [9:0] OFF_PARAM_BASE = 10'h100;
	localparam logic [9:0] OFF_ACT_SIZE_RD = 10'h040;
	localparam logic [9:0] OFF_ACT_PARAM_BASE = 10'h200;
	localparam int NUM_PARAMS = 13;
	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_COMMIT_BIT = 1;
	localparam int CTRL_SYNC_RESET_BIT = 31;
	localparam int CTRL_SOFT_RESET_BIT = 30;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0002;
	localparam logic [31:0] SIZE_RESET = 32'h0000_0000;
	localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
	// arbitrary identification value
	localparam logic [31:0] VERSION_VALUE = 32'h0001_0000;
	// ----------------------------------------
	// timing and datapath
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SYNC_RESET_NS = 320;
	localparam int SYNC_RESET_CYCLES = SYNC_RESET_NS / CLK_PERIOD_NS;
	localparam int DATA_W = 24;
	localparam int FIFO_DEPTH = 16;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	typedef enum logic [1:0] {
		RST_IDLE = 2'b00,
		RST_WAIT = 2'b01,
		RST_HOLD = 2'b10
	} rst_state_t;
endpackage

// File: logic/stream_fifo.sv
// parameterised valid/ready FIFO with flush
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	// clock and resets
	input wire logic clk,
	input wire logic resetn,
	input wire logic flush,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign inReady = (count_r != (AW+1)'(DEPTH)) && !flush;
	assign outValid = (count_r != '0) && !flush;
	assign outData = mem[rdPtr_r];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn || flush) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: logic/shadow_bank.sv
// double-buffered register bank: shadow copy written by software, active copy used
`timescale 1ns/1ps
`default_nettype none
module shadow_bank #(
	parameter int N = 14,
	parameter logic [31:0] INIT = 32'h0000_0000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// software write
	input wire logic wrEn,
	input wire logic [3:0] wrIdx,
	input wire logic [31:0] wrData,
	// transfer
	input wire logic commit,
	// contents
	output logic [31:0] shadowQ [N],
	output logic [31:0] activeQ [N]
);
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_reg
			always_ff @(posedge clk) begin
				if (!rstn) begin
					shadowQ[g] <= INIT;
				end else if (wrEn && wrIdx == 4'(g)) begin
					shadowQ[g] <= wrData;
				end
			end
			always_ff @(posedge clk) begin
				if (!rstn) begin
					activeQ[g] <= INIT;
				end else if (commit) begin
					activeQ[g] <= shadowQ[g];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// File: logic/csc_ctrl.sv
// colour-space converter control: registers, resets, shadow update, stream path
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - soft reset clears registers, FIFO, stream handshakes
// - control bit 30 resets at once, holds
// - clearing bit 30 resumes, resyncing to frame
// - sync reset after frame, held 32 cycles
// - sync reset immediate when no frame active
// - stalled frame keeps sync reset deferred
// - parameter writes land in shadow copies
// - shadow copied to active at frame start if commit
// - registers accessed as full 32-bit words
module csc_ctrl import csc_ctrl_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// input video stream
	input wire logic [DATA_W-1:0] inStreamData,
	input wire logic inStreamValid,
	input wire logic in_stream_frame_start,
	input wire logic inStreamLast,
	output logic in_stream_ready,
	// output video stream
	output logic [DATA_W-1:0] outStreamData,
	output logic out_stream_valid,
	output logic outStreamFrameStart,
	input wire logic outStreamReady
);
	// ----------------------------------------
	// reset sequencing
	// ----------------------------------------
	localparam int NREG = NUM_PARAMS + 1;
	logic [31:0] control_r;
	rst_state_t rstState_r;
	logic [5:0] holdCnt_r;
	logic inFrame_r;
	logic syncedToFrame_r;
	logic coreRstn;
	logic syncReq;
	logic inBeat;
	logic frameDone;

	assign inBeat = inStreamValid && in_stream_ready;
	// a frame ends on its last line's end or when a new frame begins
	assign frameDone = (inBeat && inStreamLast) || (inStreamValid && in_stream_frame_start);
	assign syncReq = control_r[CTRL_SYNC_RESET_BIT];
	// internal core reset: pin, software hold, or timed sync pulse
	assign coreRstn = resetn && !control_r[CTRL_SOFT_RESET_BIT] && rstState_r != RST_HOLD;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rstState_r <= RST_IDLE;
			holdCnt_r <= '0;
		end else begin
			case (rstState_r)
				RST_IDLE: begin
					if (syncReq) begin
						if (!inFrame_r) begin
							rstState_r <= RST_HOLD;
						end else begin
							rstState_r <= RST_WAIT;
						end
						holdCnt_r <= '0;
					end
				end
				RST_WAIT: begin
					// a stalled stream leaves us here indefinitely
					if (frameDone || !inFrame_r) begin
						rstState_r <= RST_HOLD;
					end
				end
				RST_HOLD: begin
					if (holdCnt_r == 6'(SYNC_RESET_CYCLES - 1)) begin
						rstState_r <= RST_IDLE;
					end
					holdCnt_r <= holdCnt_r + 1'b1;
				end
				default: begin
					rstState_r <= RST_IDLE;
				end
			endcase
		end
	end

	// frame tracking; after reset wait for a frame start before keeping data
	always_ff @(posedge core_clk) begin
		if (!coreRstn) begin
			inFrame_r <= 1'b0;
			syncedToFrame_r <= 1'b0;
		end else begin
			if (inStreamValid && in_stream_frame_start) begin
				syncedToFrame_r <= 1'b1;
			end
			if (inBeat && inStreamLast) begin
				inFrame_r <= 1'b0;
			end else if (inBeat) begin
				inFrame_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// ahb-lite slave
	// ----------------------------------------
	logic pendWr_r;
	logic pendRd_r;
	logic [9:0] pendAddr_r;
	logic addrOk;
	logic takeAddr;

	function automatic logic isMapped(input logic [31:0] a);
		logic [9:0] o;
		o = a[9:0];
		isMapped = (a[31:10] == '0) && (a[1:0] == 2'b00) &&
			(o == OFF_CONTROL || o == OFF_STATUS || o == OFF_VERSION ||
			o == OFF_ACTIVE_SIZE || o == OFF_ACT_SIZE_RD ||
			(o >= OFF_PARAM_BASE && o < OFF_PARAM_BASE + 10'(4 * NUM_PARAMS)) ||
			(o >= OFF_ACT_PARAM_BASE && o < OFF_ACT_PARAM_BASE + 10'(4 * NUM_PARAMS)));
	endfunction

	// bank index: 0 is the frame size, 1.. are the conversion parameters
	function automatic logic [3:0] bankIdx(input logic [9:0] o);
		logic [9:0] d;
		d = '0;
		if (o == OFF_ACTIVE_SIZE || o == OFF_ACT_SIZE_RD) begin
			bankIdx = 4'h0;
		end else begin
			d = (o >= OFF_ACT_PARAM_BASE) ? o - OFF_ACT_PARAM_BASE : o - OFF_PARAM_BASE;
			bankIdx = 4'(d[9:2] + 8'h01);
		end
	endfunction

	// only whole-word transfers are honoured
	assign addrOk = isMapped(haddr) && hsize == HSIZE_WORD;
	assign takeAddr = hsel && hready && htrans == HTRANS_NONSEQ;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pendWr_r <= 1'b0;
			pendRd_r <= 1'b0;
			pendAddr_r <= '0;
		end else begin
			pendWr_r <= takeAddr && hwrite && addrOk;
			pendRd_r <= takeAddr && !hwrite && addrOk;
			if (takeAddr) begin
				pendAddr_r <= haddr[9:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------
	// control register and shadow bank
	// ----------------------------------------
	logic bankWr;
	logic sofCommit;
	logic [31:0] shadowQ [NREG];
	logic [31:0] activeQ [NREG];
	logic bankRstn;

	// software reset clears the register file too; so does the sync-reset hold
	assign bankRstn = resetn && !control_r[CTRL_SOFT_RESET_BIT] && rstState_r != RST_HOLD;
	assign bankWr = pendWr_r && (pendAddr_r == OFF_ACTIVE_SIZE ||
		(pendAddr_r >= OFF_PARAM_BASE && pendAddr_r < OFF_ACT_PARAM_BASE));
	// commit clear leaves the active set alone and the shadow untouched
	assign sofCommit = inBeat && in_stream_frame_start && control_r[CTRL_COMMIT_BIT];

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			control_r <= CONTROL_RESET;
		end else if (pendWr_r && pendAddr_r == OFF_CONTROL) begin
			control_r <= hwdata;
		end else if (control_r[CTRL_SOFT_RESET_BIT]) begin
			control_r <= CONTROL_RESET | (32'h1 << CTRL_SOFT_RESET_BIT);
		end else if (rstState_r == RST_HOLD) begin
			// sync request consumed; control returns to CONTROL_RESET, so software must set the enable bit again
			control_r <= CONTROL_RESET;
		end
	end

	shadow_bank #(
		.N(NREG),
		.INIT(PARAM_RESET)
	) u_bank (
		.clk(core_clk),
		.rstn(bankRstn),
		.wrEn(bankWr),
		.wrIdx(bankIdx(pendAddr_r)),
		.wrData(hwdata),
		.commit(sofCommit),
		.shadowQ(shadowQ),
		.activeQ(activeQ)
	);

	// read data is registered from the address phase
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			hrdata <= '0;
		end else if (takeAddr && !hwrite && addrOk) begin
			if (haddr[9:0] == OFF_CONTROL) begin
				hrdata <= control_r;
			end else if (haddr[9:0] == OFF_STATUS) begin
				hrdata <= {28'h0, syncedToFrame_r, inFrame_r, rstState_r};
			end else if (haddr[9:0] == OFF_VERSION) begin
				hrdata <= VERSION_VALUE;
			end else if (haddr[9:0] >= OFF_ACT_PARAM_BASE || haddr[9:0] == OFF_ACT_SIZE_RD) begin
				hrdata <= activeQ[bankIdx(haddr[9:0])];
			end else begin
				hrdata <= shadowQ[bankIdx(haddr[9:0])];
			end
		end else begin
			hrdata <= '0;
		end
	end

	// ----------------------------------------
	// stream path through the buffer
	// ----------------------------------------
	localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;
	logic fifoOutValid;
	logic [DATA_W:0] fifoOutData;
	logic keepBeat;
	logic push;
	logic outTake;
	logic [LVL_W-1:0] level_r;
	logic roomLeft;

	// beats ahead of the first frame start are taken and dropped, so a source
	// caught mid-frame by a reset cannot wedge the input
	assign keepBeat = syncedToFrame_r || in_stream_frame_start;
	assign push = inBeat && keepBeat;
	assign outTake = fifoOutValid && (!out_stream_valid || outStreamReady);
	// ready is registered, so one more beat can land after it is computed:
	// keep a slot in hand instead of trusting the buffer's own full flag
	assign roomLeft = level_r < LVL_W'(FIFO_DEPTH - 1);

	// mirror of the buffer's fill level, cleared together with its flush
	always_ff @(posedge core_clk) begin
		if (!coreRstn) begin
			level_r <= '0;
		end else if (push && !outTake) begin
			level_r <= level_r + 1'b1;
		end else if (outTake && !push) begin
			level_r <= level_r - 1'b1;
		end
	end

	stream_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(core_clk),
		.resetn(resetn),
		.flush(!coreRstn),
		.inValid(push),
		.inReady(),
		.inData({in_stream_frame_start, inStreamData}),
		.outValid(fifoOutValid),
		.outReady(coreRstn && (!out_stream_valid || outStreamReady)),
		.outData(fifoOutData)
	);

	always_ff @(posedge core_clk) begin
		if (!coreRstn) begin
			in_stream_ready <= 1'b0;
		end else begin
			in_stream_ready <= control_r[CTRL_ENABLE_BIT] && roomLeft;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!coreRstn) begin
			out_stream_valid <= 1'b0;
			outStreamData <= '0;
			outStreamFrameStart <= 1'b0;
		end else if (outTake) begin
			out_stream_valid <= 1'b1;
			outStreamData <= fifoOutData[DATA_W-1:0];
			outStreamFrameStart <= fifoOutData[DATA_W];
		end else if (outStreamReady) begin
			out_stream_valid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: verif/csc_ctrl_assertions.sv
// port checker for the colour-space control block
`timescale 1ns/1ps
`default_nettype none
module csc_ctrl_checker import csc_ctrl_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// stream
	input wire logic in_stream_ready,
	input wire logic [DATA_W-1:0] outStreamData,
	input wire logic out_stream_valid,
	input wire logic outStreamReady
);
	logic rdP, wrP, softR, syncW;
	logic [31:0] adr;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	always_ff @(posedge core_clk) adr <= haddr;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdP <= 1'b0;
			wrP <= 1'b0;
			softR <= 1'b0;
			syncW <= 1'b0;
		end else begin
			rdP <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
			wrP <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
			if (wrP && adr == 32'h0) begin
				softR <= hwdata[CTRL_SOFT_RESET_BIT];
				syncW <= syncW || hwdata[CTRL_SYNC_RESET_BIT];
			end
		end
	end
	hresp_okay_a: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	ready_high_a: assert property (hreadyout == 1'b1)
		else $error("wait state inserted");
	idle_rdata_a: assert property (!rdP |-> hrdata == 32'h0)
		else $error("read data outside data phase");
	version_read_a: assert property (rdP && adr == 32'h10 |-> hrdata == VERSION_VALUE)
		else $error("version read wrong");
	reset_quiet_a: assert property ($rose(resetn) |-> !out_stream_valid && !in_stream_ready)
		else $error("stream active out of reset");
	soft_quiet_a: assert property (softR [*3] |-> !out_stream_valid && !in_stream_ready)
		else $error("stream active in soft reset");
	soft_ctrl_a: assert property (softR && $past(softR, 2) && rdP && adr == 32'h0
		|-> hrdata == 32'h4000_0002) else $error("control not reverted in soft reset");
	out_hold_a: assert property (disable iff (!resetn || softR || syncW)
		out_stream_valid && !outStreamReady |=> out_stream_valid && $stable(outStreamData))
		else $error("output beat dropped while stalled");
endmodule
bind csc_ctrl csc_ctrl_checker chk_u (.core_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hreadyout, .hresp, .hrdata, .in_stream_ready, .outStreamData,
	.out_stream_valid, .outStreamReady);
`default_nettype wire

// File: verif/stream_partner.sv
// upstream video source and downstream sink model
`timescale 1ns/1ps
`default_nettype none
module stream_partner import csc_ctrl_pkg::*; (
	// bench control
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic pause,
	input wire logic stall,
	// source side
	output logic [DATA_W-1:0] inStreamData,
	output logic inStreamValid,
	output logic in_stream_frame_start,
	output logic inStreamLast,
	input wire logic in_stream_ready,
	// sink side
	output logic outStreamReady
);
	logic [2:0] left;
	assign outStreamReady = !stall;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			left <= 3'h0;
			inStreamValid <= 1'b0;
			inStreamData <= 24'h0;
			in_stream_frame_start <= 1'b0;
			inStreamLast <= 1'b0;
		end else if (inStreamValid && !in_stream_ready) begin
			// an offered beat is held until taken, even across a core reset
			left <= left;
		end else if (start) begin
			left <= 3'h4;
			inStreamValid <= 1'b0;
		end else if (left != 3'h0 && !pause && !inStreamValid) begin
			inStreamValid <= 1'b1;
			in_stream_frame_start <= left == 3'h4;
			inStreamLast <= left == 3'h1;
			inStreamData <= {21'h0, left};
			left <= left - 3'h1;
		end else begin
			inStreamValid <= 1'b0;
			inStreamData <= ~inStreamData;
		end
	end
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the colour-space control block
`timescale 1ns/1ps
`default_nettype none
module tb import csc_ctrl_pkg::*;;
	logic core_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic start = 1'b0, pause = 1'b0, stall = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = HSIZE_WORD;
	logic hreadyout, hresp, inStreamValid, in_stream_frame_start, inStreamLast;
	logic in_stream_ready, out_stream_valid, outStreamFrameStart, outStreamReady;
	logic [DATA_W-1:0] inStreamData, outStreamData;
	int numErrors = 0, numChecks = 0, beats = 0, sum = 0, n, m, i;
	always #5 core_clk = ~core_clk;
	// each taken output beat adds its pixel, plus 256 when it opens a frame
	always @(posedge core_clk) begin
		if (out_stream_valid && outStreamReady) begin
			beats <= beats + 1;
			sum <= sum + int'(outStreamData) + (outStreamFrameStart ? 256 : 0);
		end
	end
	csc_ctrl dut_u (.core_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .inStreamData, .inStreamValid,
		.in_stream_frame_start, .inStreamLast, .in_stream_ready, .outStreamData,
		.out_stream_valid, .outStreamFrameStart, .outStreamReady);
	stream_partner src_u (.core_clk, .resetn, .start, .pause, .stall, .inStreamData,
		.inStreamValid, .in_stream_frame_start, .inStreamLast, .in_stream_ready, .outStreamReady);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		numChecks++;
		if (g !== e) begin
			numErrors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, d, input logic [2:0] s);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		hsize <= s;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		xfer(1'b1, a, d, HSIZE_WORD);
	endtask
	task automatic rdc(input logic [31:0] a, e);
		xfer(1'b0, a, 32'h0, HSIZE_WORD);
		chk($sformatf("reg %h", a), e, q);
	endtask
	task automatic frame();
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		repeat (20) @(posedge core_clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rdc(32'h0, CONTROL_RESET);
		rdc(32'h8, 32'h0);
		rdc(32'h10, VERSION_VALUE);
		wr(32'h0, 32'h1);
		wr(32'h20, 32'h00A5_005A);
		wr(32'h130, 32'h0000_1234);
		rdc(32'h20, 32'h00A5_005A);
		rdc(32'h40, SIZE_RESET);
		frame();
		rdc(32'h40, SIZE_RESET);
		rdc(32'h230, PARAM_RESET);
		rdc(32'h20, 32'h00A5_005A);
		wr(32'h0, 32'h3);
		frame();
		rdc(32'h40, 32'h00A5_005A);
		rdc(32'h230, 32'h0000_1234);
		xfer(1'b1, 32'h20, 32'h0000_00FF, 3'h0);
		rdc(32'h20, 32'h00A5_005A);
		// stalled sink leaves beats queued when the soft reset hits
		stall <= 1'b1;
		frame();
		wr(32'h0, 32'h4000_0003);
		repeat (2) @(posedge core_clk);
		rdc(32'h0, 32'h4000_0002);
		rdc(32'h40, SIZE_RESET);
		chk("inReady", 32'h0, {31'h0, in_stream_ready});
		wr(32'h0, 32'h0);
		wr(32'h0, 32'h3);
		n = beats;
		m = sum;
		stall <= 1'b0;
		frame();
		chk("beatsOut", 32'h4, 32'(beats - n));
		chk("beatData", 32'h10A, 32'(sum - m));
		wr(32'h0, 32'h8000_0003);
		// the reset state moves one edge after the control write lands
		@(posedge core_clk);
		xfer(1'b0, 32'h4, 32'h0, HSIZE_WORD);
		chk("state", 32'h2, {30'h0, q[1:0]});
		n = 0;
		while (q[1:0] === 2'h2 && n < 40) begin
			n++;
			xfer(1'b0, 32'h4, 32'h0, HSIZE_WORD);
		end
		chk("holdReads", 32'h1, {31'h0, n >= 15 && n <= 17});
		chk("state", 32'h0, {30'h0, q[1:0]});
		rdc(32'h0, CONTROL_RESET);
		wr(32'h0, 32'h3);
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		for (i = 0; i < 50 && !(inStreamValid && in_stream_ready); i++) @(posedge core_clk);
		pause <= 1'b1;
		wr(32'h0, 32'h8000_0003);
		repeat (20) @(posedge core_clk);
		xfer(1'b0, 32'h4, 32'h0, HSIZE_WORD);
		chk("state", 32'h1, {30'h0, q[1:0]});
		pause <= 1'b0;
		i = 0;
		do begin
			xfer(1'b0, 32'h4, 32'h0, HSIZE_WORD);
			i++;
		end while (q[1:0] !== 2'h2 && i < 20);
		chk("state", 32'h2, {30'h0, q[1:0]});
		repeat (40) @(posedge core_clk);
		print_verdict();
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		numErrors++;
		print_verdict();
	end
endmodule
`default_nettype wire
